/* File: src/ebus_phase_seq.sv */
// External bus phase sequencer: runs each access through up to five phases.
// Assumes synchronous request inputs and an external partner that holds
// read data until the read strobe has risen.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Every cycle runs AB and E; C, D and F only when their length is non-zero.
// - Phase lengths come from window's timing word.
// - Setup 1-2 periods, plus 0-3 on window change.
// - Command delay 0-3, data setup 0-1.
// - Access 1-32, hold 0-3 periods.
// - Read data captured on strobe-rising edge.
// - Early address change cannot corrupt read data.
module ebus_phase_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Timing word writes
    input wire logic tctrl_wr,
    input wire logic [ebus_pkg::WIN_W-1:0] tctrl_idx,
    input wire ebus_pkg::chip_select_timing_ctrl_t tctrl_data,
    // Request / answer
    input wire logic req_valid,
    input wire ebus_pkg::bus_req_s req,
    output logic req_ready,
    output ebus_pkg::bus_ans_s ans,
    // External bus
    output logic bus_reference_clock_out,
    output logic [ebus_pkg::ADDR_W-1:0] addr_out,
    output logic [ebus_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [ebus_pkg::DATA_W-1:0] data_in,
    output logic rd_n,
    output logic wr_n,
    output logic ale,
    output logic [ebus_pkg::WIN_W-1:0] cs_win
);
    import ebus_pkg::*;

    // ********************************
    // Phase length decode
    // ********************************
    // Remaining-count load value: length minus one, 6 bits
    function automatic logic [5:0] len_m1(input chip_select_timing_ctrl_t t, input phase_e p,
                                           input logic chg);
        logic [5:0] n;
        n = 6'h00;
        case (p)
            ST_AB: n = AB_BASE_MIN + {5'h00, t[AB_POS]}
                       + (chg ? {4'h0, t[X_POS +: 2]} : 6'h00) - 6'h01;
            ST_C: n = {4'h0, t[C_POS +: 2]} - 6'h01;
            ST_D: n = {5'h00, t[D_POS]} - 6'h01;
            ST_E: n = {1'b0, t[E_POS +: 5]} + E_MIN - 6'h01;
            ST_F: n = {4'h0, t[F_POS +: 2]} - 6'h01;
            default: n = 6'h00;
        endcase
        return n;
    endfunction : len_m1

    // Zero-length phases are skipped
    function automatic logic is_zero(input chip_select_timing_ctrl_t t, input phase_e p);
        logic z;
        z = 1'b0;
        case (p)
            ST_C: z = (t[C_POS +: 2] == 2'h0);
            ST_D: z = (t[D_POS] == 1'b0);
            ST_F: z = (t[F_POS +: 2] == 2'h0);
            default: z = 1'b0;
        endcase
        return z;
    endfunction : is_zero

    // ********************************
    // Timing store and request latch
    // ********************************
    chip_select_timing_ctrl_t tword;
    bus_req_s cur_r;
    logic [WIN_W-1:0] last_win_r;
    logic win_chg_r;
    phase_e st_r;
    phase_e st_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic load_r;
    logic take_r;

    ebus_timing_store #(
        .N(NUM_WIN),
        .AW(WIN_W)
    ) u_store (
        .clk(clk),
        .nrst(nrst),
        .wr_en(tctrl_wr),
        .wr_idx(tctrl_idx),
        .wr_data(tctrl_data),
        .rd_idx(cur_r.win),
        .rd_data(tword)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_r <= '0;
            win_chg_r <= 1'b0;
            last_win_r <= '0;
        end else if (st_r == ST_IDLE && req_valid && req_ready) begin
            cur_r <= req;
            win_chg_r <= (req.win != last_win_r);
            last_win_r <= req.win;
        end
    end

    // ********************************
    // Phase sequencing
    // ********************************
    // Two cycles after accept: store reads the new window, then its word settles.
    // Loading one cycle earlier would use the previous window's timing.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            take_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            take_r <= (st_r == ST_IDLE) && req_valid && req_ready;
            load_r <= take_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_IDLE: begin
                if (load_r) begin
                    // Every access starts with address setup
                    st_nxt = ST_AB;
                    cnt_nxt = len_m1(tword, ST_AB, win_chg_r);
                end
            end
            ST_AB, ST_C, ST_D, ST_E: begin
                if (cnt_r != 6'h00) begin
                    cnt_nxt = cnt_r - 6'h01;
                end else begin
                    // Walk to the next phase, skipping empty ones
                    // Empty command delay and data setup skipped
                    st_nxt = (st_r == ST_AB) ? ST_C : (st_r == ST_C) ? ST_D : (st_r == ST_D) ? ST_E : ST_F;
                    if (st_nxt == ST_C && is_zero(tword, ST_C)) begin
                        st_nxt = ST_D;
                    end
                    if (st_nxt == ST_D && is_zero(tword, ST_D)) begin
                        st_nxt = ST_E;
                    end
                    // Empty hold goes straight to idle
                    if (st_nxt == ST_F && is_zero(tword, ST_F)) begin
                        st_nxt = ST_IDLE;
                    end
                    cnt_nxt = len_m1(tword, st_nxt, win_chg_r);
                end
            end
            ST_F: begin
                if (cnt_r != 6'h00) begin
                    cnt_nxt = cnt_r - 6'h01;
                end else begin
                    st_nxt = ST_IDLE;
                    cnt_nxt = 6'h00;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
                cnt_nxt = 6'h00;
            end
        endcase
    end

    // All phase changes on the CPU clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            cnt_r <= 6'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ********************************
    // Bus pins
    // ********************************
    // Reference clock toggles each rising edge, so it runs at half rate
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_reference_clock_out <= 1'b0;
        end else begin
            bus_reference_clock_out <= ~bus_reference_clock_out;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_out <= '0;
            cs_win <= '0;
            ale <= 1'b0;
        end else begin
            ale <= (st_nxt == ST_AB);
            if (st_nxt != ST_IDLE) begin
                addr_out <= cur_r.addr;
                cs_win <= cur_r.win;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            rd_n <= !(st_nxt == ST_E && !cur_r.write);
            wr_n <= !(st_nxt == ST_E && cur_r.write);
        end
    end

    // Write data driven from data setup through hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_out <= '0;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= cur_r.wdata;
            data_oe_n <= !(cur_r.write && (st_nxt == ST_D || st_nxt == ST_E || st_nxt == ST_F));
        end
    end

    // ********************************
    // Read capture and answer
    // ********************************
    // Sample on the edge that raises the read strobe
    // Captured before any address change can matter
    // Relies on partner holding data through this edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ans <= '0;
        end else begin
            ans.done <= (st_r != ST_IDLE) && (st_nxt == ST_IDLE);
            if (st_r == ST_E && st_nxt != ST_E && !cur_r.write) begin
                ans.rdata <= data_in;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (st_nxt == ST_IDLE) && !load_r && !take_r && !((st_r == ST_IDLE) && req_valid && req_ready);
        end
    end

endmodule : ebus_phase_seq
`default_nettype wire

/* File: common/ebus_pkg.sv */
// Package: shared types and constants for the external bus phase sequencer.
// Assumes one CPU clock; phase lengths come per chip-select window.
package ebus_pkg;

    // ********************************
    // Widths
    // ********************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_WIN = 4;
    localparam int WIN_W = 2;

    // ********************************
    // Phase length limits, in CPU clock periods
    // ********************************
    localparam logic [5:0] AB_BASE_MIN = 6'h01;
    localparam logic [5:0] E_MIN = 6'h01;
    localparam logic [1:0] WIN_CHANGE_EXTRA_MAX = 2'h3;

    // ********************************
    // Timing field layout of chip_select_timing_ctrl
    // ********************************
    localparam int AB_POS = 0;   // 1 bit: 0 -> 1 period, 1 -> 2 periods
    localparam int C_POS = 1;    // 2 bits: 0..3
    localparam int D_POS = 3;    // 1 bit: 0..1
    localparam int E_POS = 4;    // 5 bits: value + 1 -> 1..32
    localparam int F_POS = 9;    // 2 bits: 0..3
    localparam int X_POS = 11;   // 2 bits: extra on window change 0..3
    localparam int TCTRL_W = 13;
    localparam logic [TCTRL_W-1:0] TCTRL_RESET = 13'h1_FFF;

    typedef logic [TCTRL_W-1:0] chip_select_timing_ctrl_t;

    // ********************************
    // Bus request and answer
    // ********************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic [WIN_W-1:0] win;
    } bus_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic done;
    } bus_ans_s;

    // Gray along the usual path idle->ab->c->d->e->f
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_AB = 3'h1,
        ST_C = 3'h3,
        ST_D = 3'h2,
        ST_E = 3'h6,
        ST_F = 3'h7
    } phase_e;

endpackage : ebus_pkg

/* File: src/ebus_timing_store.sv */
// Store of the per-window timing control words, registered read.
// Assumes writes come from the CPU side in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module ebus_timing_store #(
    parameter int N = ebus_pkg::NUM_WIN,
    parameter int AW = ebus_pkg::WIN_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire ebus_pkg::chip_select_timing_ctrl_t wr_data,
    // Read port
    input wire logic [AW-1:0] rd_idx,
    output ebus_pkg::chip_select_timing_ctrl_t rd_data
);
    import ebus_pkg::*;

    chip_select_timing_ctrl_t mem_r [N];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                mem_r[i] <= TCTRL_RESET;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= TCTRL_RESET;
        end else begin
            rd_data <= mem_r[rd_idx];
        end
    end

endmodule : ebus_timing_store
`default_nettype wire

/* File: tb/ebus_phase_seq_sva.sv */
// Port checker for the bus phase sequencer.
// Assumes one clock domain, bound onto ebus_phase_seq.
`timescale 1ns/100ps
`default_nettype none
module ebus_phase_seq_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire ebus_pkg::bus_ans_s ans,
    // Bus side
    input wire logic bus_reference_clock_out,
    input wire logic [ebus_pkg::ADDR_W-1:0] addr_out,
    input wire logic data_oe_n,
    input wire logic [ebus_pkg::DATA_W-1:0] data_in,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale
);
    import ebus_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_one_strobe;
        !(!rd_n && !wr_n);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_ale_quiet;
        ale |-> rd_n && wr_n;
    endproperty
    a_ale_quiet: assert property (p_ale_quiet) else $error("strobe during setup");
    property p_busy;
        req_valid && req_ready |=> !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready after take");
    property p_len;
        req_valid && req_ready |-> ##[5:47] ans.done;
    endproperty
    a_len: assert property (p_len) else $error("cycle too long");
    property p_pulse;
        ans.done |-> req_ready ##1 !ans.done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done not a pulse");
    property p_capture;
        $rose(rd_n) |-> ans.rdata == $past(data_in);
    endproperty
    a_capture: assert property (p_capture) else $error("read data edge");
    property p_wr_drive;
        !wr_n |-> !data_oe_n && $stable(addr_out);
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
    property p_refclk;
        $past(nrst) |-> bus_reference_clock_out != $past(bus_reference_clock_out);
    endproperty
    a_refclk: assert property (p_refclk) else $error("reference clock stuck");
    property p_idle_strobe;
        !rd_n || !wr_n |-> !req_ready;
    endproperty
    a_idle_strobe: assert property (p_idle_strobe) else $error("strobe while idle");
endmodule : ebus_phase_seq_sva
bind ebus_phase_seq ebus_phase_seq_sva chk_u (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .ans(ans), .bus_reference_clock_out(bus_reference_clock_out),
    .addr_out(addr_out), .data_oe_n(data_oe_n), .data_in(data_in), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
`default_nettype wire

/* File: tb/ebus_mem_model.sv */
// Behavioural external memory for read cycles.
// Assumes the read strobe is registered on clk.
`timescale 1ns/100ps
`default_nettype none
module ebus_mem_model (
    // Clock and mode
    input wire logic clk,
    input wire logic slow,
    // Bus
    input wire logic rd_n,
    input wire logic [ebus_pkg::ADDR_W-1:0] addr,
    output logic [ebus_pkg::DATA_W-1:0] data
);
    logic [ebus_pkg::DATA_W-1:0] last_r;
    logic wait_r;
    always_ff @(posedge clk) begin
        wait_r <= rd_n;
        if (!rd_n) begin
            last_r <= addr[15:0] ^ 16'hA5A5;
        end
    end
    // held until strobe rises
    // Released bus shows inverse, slow mode adds a late cycle
    always_comb data = (!rd_n && !(slow && wait_r)) ? addr[15:0] ^ 16'hA5A5 : ~last_r;
endmodule : ebus_mem_model
`default_nettype wire

/* File: tb/external_bus_phase_sequencer_tb.sv */
// Self-checking bench for ebus_phase_seq with a memory model.
// Assumes the 40 MHz clock and the timing word layout of ebus_pkg.
`timescale 1ns/100ps
`default_nettype none
module external_bus_phase_sequencer_tb;
    import ebus_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, tctrl_wr = 1'h0, req_valid = 1'h0, slow = 1'h0;
    logic [WIN_W-1:0] tctrl_idx = '0, cs_win;
    chip_select_timing_ctrl_t tctrl_data = '0;
    bus_req_s req = '0;
    bus_ans_s ans;
    logic req_ready, refclk, data_oe_n, rd_n, wr_n, ale;
    logic [ADDR_W-1:0] addr_out;
    logic [DATA_W-1:0] data_out, data_in;
    int errors = 0, check_count = 0;
    always #12.5 clk = ~clk;
    ebus_phase_seq dut_u (.clk(clk), .nrst(nrst), .tctrl_wr(tctrl_wr), .tctrl_idx(tctrl_idx),
        .tctrl_data(tctrl_data), .req_valid(req_valid), .req(req), .req_ready(req_ready), .ans(ans),
        .bus_reference_clock_out(refclk), .addr_out(addr_out), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_in(data_in), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .cs_win(cs_win));
    ebus_mem_model mem_u (.clk(clk), .slow(slow), .rd_n(rd_n), .addr(addr_out), .data(data_in));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    function automatic chip_select_timing_ctrl_t tw(input logic [1:0] x, input logic [1:0] f,
        input logic [4:0] em1, input logic d, input logic [1:0] c, input logic ab);
        return {x, f, em1, d, c, ab};
    endfunction : tw
    // One access: cycles, setup, strobe width, window and data
    task automatic access(input logic [1:0] w, input logic wr, input chip_select_timing_ctrl_t t,
        input int len, input int nab, input int ne);
        int n = 0, na = 0, ns = 0, bad = 0;
        logic [ADDR_W-1:0] a;
        a = 24'h12_3450 + w;
        @(posedge clk);
        tctrl_wr <= 1'h1;
        tctrl_idx <= w;
        tctrl_data <= t;
        @(posedge clk);
        tctrl_wr <= 1'h0;
        req_valid <= 1'h1;
        req <= '{addr: a, wdata: ~a[15:0], write: wr, win: w};
        @(posedge clk);
        req_valid <= 1'h0;
        while (ans.done !== 1'h1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
            na += int'(ale === 1'h1);
            ns += int'(rd_n === 1'h0 || wr_n === 1'h0);
            if (wr_n === 1'h0 && data_out !== ~a[15:0]) bad++;
            if (!wr && data_oe_n !== 1'h1) bad++;
        end
        chk("cycles", len, n);
        chk("setup", nab, na);
        chk("strobe", ne, ns);
        chk("window", w, cs_win);
        chk("addr", a, addr_out);
        chk("wdata", 0, bad);
        if (!wr) chk("rdata", a[15:0] ^ 16'hA5A5, ans.rdata);
    endtask : access
    task automatic s_cmd_delay();
        for (int c = 0; c < 4; c++) access(0, 0, tw(0, 0, 0, 0, c[1:0], 0), 4 + c, 1, 1);
    endtask : s_cmd_delay
    task automatic s_windows();
        access(0, 1, tw(3, 3, 31, 1, 3, 1), 43, 2, 32);
        access(1, 0, tw(3, 0, 0, 0, 0, 1), 8, 5, 1);
        access(1, 0, tw(3, 0, 0, 0, 0, 1), 5, 2, 1);
    endtask : s_windows
    task automatic s_slow();
        slow <= 1'h1;
        access(2, 0, tw(0, 0, 3, 0, 0, 0), 7, 1, 4);
        slow <= 1'h0;
    endtask : s_slow
    // Abort mid cycle must free the bus at once
    task automatic s_mid_reset();
        access(3, 0, tw(0, 0, 7, 0, 0, 0), 11, 1, 8);
        @(posedge clk);
        req_valid <= 1'h1;
        @(posedge clk);
        req_valid <= 1'h0;
        repeat (4) @(posedge clk);
        nrst <= 1'h0;
        #1;
        chk("rd_n", 1, rd_n);
        chk("ready", 0, req_ready);
        @(posedge clk);
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        access(0, 0, tw(0, 0, 0, 0, 0, 0), 4, 1, 1);
    endtask : s_mid_reset
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("ready", 1, req_ready);
        s_cmd_delay();
        s_windows();
        s_slow();
        s_mid_reset();
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule : external_bus_phase_sequencer_tb
`default_nettype wire
